// File: hpa_addr_match.sv
// Purpose: two-wire address compare
// Assumes: address byte holds 7-bit address in [7:1] and direction in [0]
// Notes:   purely combinational
`timescale 1ns/1ps
module hpa_addr_match
(
    // address byte and direction
    input  wire logic [7:0] dev_byte,
    input  wire logic       is_write,
    // configuration
    input  wire logic [3:0] second_msbs,
    input  wire logic [1:0] pin_choice,
    // selector pins
    input  wire logic       input_pin_zero,
    input  wire logic       input_pin_one,
    input  wire logic       input_pin_four,
    // result
    output logic            hit,
    output logic [1:0]      pair_sel
);
    logic       pin_level;
    logic       use_second;
    logic [3:0] base_msbs;

    always_comb
    begin
        case (hpa_pkg::hpa_pin_choice_e'(pin_choice))
            hpa_pkg::HPA_PIN_ZERO: pin_level = input_pin_zero;
            hpa_pkg::HPA_PIN_ONE:  pin_level = input_pin_one;
            hpa_pkg::HPA_PIN_FOUR: pin_level = input_pin_four;
            default:               pin_level = 1'b0;
        endcase
    end

    // zero nibble keeps the default
    assign use_second = pin_level && (second_msbs != hpa_pkg::ADDR_MSBS_UNPROGRAMMED);
    assign base_msbs  = use_second ? second_msbs : hpa_pkg::DEFAULT_ADDR_MSBS;
    assign pair_sel   = dev_byte[2:1];
    assign hit        = (dev_byte[7:4] == base_msbs) && !dev_byte[3]
                        && (dev_byte[2:1] != 2'h3) && (dev_byte[0] == !is_write);

endmodule

// File: hpa_host_model.sv
// Purpose: bus front end, one byte per call
// Assumes: byte taken one edge after driving
// Notes:   data lines show inverted values when idle
`timescale 1ns/1ps
module hpa_host_model
(
    // clock
    input  wire logic       clk,
    // byte access
    output logic            xfer_valid    = 1'b0,
    output logic            xfer_spi      = 1'b0,
    output logic            xfer_first    = 1'b0,
    output logic            xfer_write    = 1'b0,
    output logic [7:0]      xfer_dev_byte = 8'h00,
    output logic [7:0]      xfer_reg      = 8'h00,
    output logic [7:0]      xfer_wdata    = 8'h00,
    output logic            xfer_end      = 1'b0,
    // answers
    input  wire logic       xfer_ack,
    input  wire logic       xfer_rvalid,
    input  wire logic [7:0] xfer_rdata,
    input  wire logic       ext_we,
    input  wire logic [9:0] ext_addr
);
    logic       seen_ack, seen_rv, seen_we;
    logic [7:0] seen_rd;
    logic [9:0] seen_addr;

    task automatic xfer(input logic v, sp, fi, wr, input logic [7:0] dev, rg, wd,
                        input logic en);
        @(posedge clk);
        xfer_valid    <= v;
        xfer_spi      <= sp;
        xfer_first    <= fi;
        xfer_write    <= wr;
        xfer_dev_byte <= dev;
        xfer_reg      <= rg;
        xfer_wdata    <= wd;
        xfer_end      <= en;
        @(posedge clk);
        xfer_valid    <= 1'b0;
        xfer_end      <= 1'b0;
        xfer_dev_byte <= ~dev;
        xfer_reg      <= ~rg;
        xfer_wdata    <= ~wd;
        #1;
        seen_ack  = xfer_ack;
        seen_rv   = xfer_rvalid;
        seen_rd   = xfer_rdata;
        seen_we   = ext_we;
        seen_addr = ext_addr;
    endtask
endmodule

// File: hpa_page_map.sv
// Purpose: page and register byte to full address
// Assumes: spi carries a 7-bit register number, two-wire an 8-bit one
// Notes:   purely combinational; mapped low marks a hole in the map
`timescale 1ns/1ps
module hpa_page_map
(
    // access
    input  wire logic       is_spi,
    input  wire logic [2:0] page_sel,
    input  wire logic [1:0] pair_sel,
    input  wire logic [7:0] reg_byte,
    // result
    output logic [9:0]      full_addr,
    output logic            mapped
);
    logic [1:0] pair;

    // base+0 follows the page field
    assign pair = (pair_sel == hpa_pkg::PAIR_PAGES_0_1) ? page_sel[2:1] : pair_sel;

    always_comb
    begin
        full_addr = 10'h000;
        mapped    = 1'b0;
        if (is_spi)
        begin
            mapped = 1'b1;
            case (hpa_pkg::hpa_spi_page_e'(page_sel))
                hpa_pkg::HPA_SPI_PAGE_0: full_addr = {3'h0, reg_byte[6:0]};
                hpa_pkg::HPA_SPI_PAGE_1: full_addr = {3'h1, reg_byte[6:0]};
                hpa_pkg::HPA_SPI_PAGE_2: full_addr = {3'h2, reg_byte[6:0]};
                hpa_pkg::HPA_SPI_PAGE_4: full_addr = {3'h4, reg_byte[6:0]};
                default:                 mapped    = 1'b0;
            endcase
        end
        else
        begin
            case (pair)
                2'h0:
                begin
                    full_addr = {2'h0, reg_byte};
                    mapped    = 1'b1;
                end
                2'h1:
                begin
                    full_addr = {3'h2, reg_byte[6:0]};
                    mapped    = !reg_byte[7];
                end
                2'h2:
                begin
                    full_addr = {3'h4, reg_byte[6:0]};
                    mapped    = !reg_byte[7];
                end
                default: mapped = 1'b0;
            endcase
        end
    end

endmodule

// File: hpa_pkg.sv
// Purpose: constants of the paging and address bank
// Assumes: 8-bit registers, 10-bit internal register addresses
// Notes:   Overview of operation
// Overview of operation
// - alternative selection answers on second address from config upper nibble
// - even address byte writes, next odd reads; base+0 follows the page upper bits, base+2/4 reach pages 2-3/4-5
// - zero second-address nibble means unprogrammed: hardware default address
// - pin choice code 00 none, 01 input zero, 10 input one, 11 input four
// - auto-return set clears page selection to 000 when the access has finished
// - two-wire write style 0 increments register per byte, 1 repeats register writes
// - two-wire page upper bits pick window 0x00-0xFF, 0x100-0x17F or 0x200-0x27F
// - spi page picks 128-register window: 000, 001, 010 or 100
package hpa_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [9:0] OFS_SECOND_BUS_ADDRESS_CONFIG = 10'h148;
    localparam logic [9:0] OFS_PAGE_CONTROL              = 10'h200;
    localparam logic [9:0] OFS_PART_IDENTIFIER           = 10'h201;
    localparam logic [9:0] OFS_REVISION_AND_VARIANT      = 10'h202;
    localparam logic [9:0] OFS_BUYER_IDENTIFIER          = 10'h203;
    localparam logic [9:0] OFS_PROGRAMMED_SETUP_REVISION = 10'h204;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ADDR_MSBS_LSB   = 4;
    localparam int ADDR_MSBS_MSB   = 7;
    localparam int PIN_CHOICE_LSB  = 0;
    localparam int PIN_CHOICE_MSB  = 1;
    localparam int AUTO_RETURN_BIT = 7;
    localparam int WRITE_STYLE_BIT = 6;
    localparam int PAGE_RSVD_LSB   = 3;
    localparam int PAGE_RSVD_MSB   = 5;
    localparam int PAGE_SEL_LSB    = 0;
    localparam int PAGE_SEL_MSB    = 2;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_SECOND_BUS_ADDRESS_CONFIG = 8'h00;
    localparam logic [7:0] RST_PAGE_CONTROL              = 8'h00;
    localparam logic [7:0] RST_POINTER                   = 8'h00;

    // ----------------------------------------------------------------
    // address codes
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_MSBS_UNPROGRAMMED = 4'h0;
    localparam logic [3:0] DEFAULT_ADDR_MSBS      = 4'hd;
    localparam logic [1:0] PAIR_PAGES_0_1         = 2'h0;
    localparam logic [1:0] PAIR_PAGES_2_3         = 2'h1;
    localparam logic [1:0] PAIR_PAGES_4_5         = 2'h2;

    // ----------------------------------------------------------------
    // enumerations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        HPA_PIN_NONE = 2'b00,
        HPA_PIN_ZERO = 2'b01,
        HPA_PIN_ONE  = 2'b10,
        HPA_PIN_FOUR = 2'b11
    } hpa_pin_choice_e;

    typedef enum logic [2:0] {
        HPA_SPI_PAGE_0 = 3'b000,
        HPA_SPI_PAGE_1 = 3'b001,
        HPA_SPI_PAGE_2 = 3'b010,
        HPA_SPI_PAGE_4 = 3'b100
    } hpa_spi_page_e;

    typedef enum logic {
        HPA_ST_IDLE  = 1'b0,
        HPA_ST_BURST = 1'b1
    } hpa_state_e;

endpackage

// File: hpa_regbank.sv
// Purpose: paging, second bus address and identification register bank
// Assumes: one data byte per xfer_valid cycle;
//          xfer_end pulses when an access ends
// Notes:   foreign registers go out on the ext_* strobes
`timescale 1ns/1ps
module hpa_regbank
#(
    parameter logic [7:0] PART_CODE          = 8'h5a, // arbitrary value
    parameter logic [3:0] MASK_REVISION      = 4'h1,  // arbitrary value
    parameter logic [3:0] VARIANT_CODE       = 4'h2,  // arbitrary value
    parameter logic [7:0] BUYER_CODE         = 8'h3c, // arbitrary value
    parameter logic [7:0] PROGRAMMED_SETUP   = 8'h01, // arbitrary value
    parameter logic [7:0] SECOND_ADDR_LOADED = hpa_pkg::RST_SECOND_BUS_ADDRESS_CONFIG
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // byte access from the bus front end
    input  wire logic       xfer_valid,
    input  wire logic       xfer_spi,
    input  wire logic       xfer_first,
    input  wire logic       xfer_write,
    input  wire logic [7:0] xfer_dev_byte,
    input  wire logic [7:0] xfer_reg,
    input  wire logic [7:0] xfer_wdata,
    input  wire logic       xfer_end,
    // answer to the front end
    output logic            xfer_ack,
    output logic            xfer_rvalid,
    output logic [7:0]      xfer_rdata,
    // address selector pins
    input  wire logic       input_pin_zero,
    input  wire logic       input_pin_one,
    input  wire logic       input_pin_four,
    // forwarded access to other banks
    output logic            ext_we,
    output logic            ext_re,
    output logic [9:0]      ext_addr,
    output logic [7:0]      ext_wdata,
    // state seen by the rest of the chip
    output logic [2:0]      page_sel,
    output logic            repeat_write
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [3:0]          second_msbs_reg;
    logic [1:0]          pin_choice_reg;
    logic                auto_return_reg;
    logic                write_style_reg;
    logic [2:0]          page_rsvd_reg;
    logic [2:0]          page_sel_reg;
    logic [7:0]          ptr_reg;
    logic [7:0]          ptr_next;

    hpa_pkg::hpa_state_e state_reg;
    hpa_pkg::hpa_state_e state_next;

    logic                ack_reg;
    logic                rvalid_reg;
    logic [7:0]          rdata_reg;

    logic                ext_we_reg;
    logic                ext_re_reg;
    logic [9:0]          ext_addr_reg;
    logic [7:0]          ext_wdata_reg;

    // ----------------------------------------------------------------
    // decode of the current byte
    // ----------------------------------------------------------------
    logic       i2c_hit;
    logic [1:0] pair_sel;
    logic       hit;
    logic       use_pointer;
    logic [7:0] cur_byte;

    logic [9:0] full_addr;
    logic       mapped;

    logic       do_access;
    logic       do_write;
    logic       do_read;

    logic       sel_addr_cfg;
    logic       sel_page_ctl;
    logic       sel_own;

    logic [7:0] own_rdata;

    hpa_addr_match u_addr_match
    (
        .dev_byte       (xfer_dev_byte),
        .is_write       (xfer_write),
        .second_msbs    (second_msbs_reg),
        .pin_choice     (pin_choice_reg),
        .input_pin_zero (input_pin_zero),
        .input_pin_one  (input_pin_one),
        .input_pin_four (input_pin_four),
        .hit            (i2c_hit),
        .pair_sel       (pair_sel)
    );

    assign hit = xfer_spi || i2c_hit;

    // burst bytes follow the pointer, repeated writes their own reg
    assign use_pointer = !xfer_first && (state_reg == hpa_pkg::HPA_ST_BURST)
                         && (xfer_spi || !xfer_write || !write_style_reg);
    assign cur_byte    = use_pointer ? ptr_next : xfer_reg;

    hpa_page_map u_page_map
    (
        .is_spi    (xfer_spi),
        .page_sel  (page_sel_reg),
        .pair_sel  (xfer_spi ? hpa_pkg::PAIR_PAGES_0_1 : pair_sel),
        .reg_byte  (cur_byte),
        .full_addr (full_addr),
        .mapped    (mapped)
    );

    assign do_access    = xfer_valid && hit && mapped;
    assign do_write     = do_access && xfer_write;
    assign do_read      = do_access && !xfer_write;

    assign sel_addr_cfg = (full_addr == hpa_pkg::OFS_SECOND_BUS_ADDRESS_CONFIG);
    assign sel_page_ctl = (full_addr == hpa_pkg::OFS_PAGE_CONTROL);

    assign sel_own      = sel_addr_cfg || sel_page_ctl
                          || (full_addr == hpa_pkg::OFS_PART_IDENTIFIER)
                          || (full_addr == hpa_pkg::OFS_REVISION_AND_VARIANT)
                          || (full_addr == hpa_pkg::OFS_BUYER_IDENTIFIER)
                          || (full_addr == hpa_pkg::OFS_PROGRAMMED_SETUP_REVISION);

    always_comb
    begin
        own_rdata = 8'h00;
        case (full_addr)
            hpa_pkg::OFS_SECOND_BUS_ADDRESS_CONFIG:
                own_rdata = {second_msbs_reg, 2'h0, pin_choice_reg};
            hpa_pkg::OFS_PAGE_CONTROL:
                own_rdata = {auto_return_reg, write_style_reg, page_rsvd_reg, page_sel_reg};
            hpa_pkg::OFS_PART_IDENTIFIER:
                own_rdata = PART_CODE;
            hpa_pkg::OFS_REVISION_AND_VARIANT:
                own_rdata = {MASK_REVISION, VARIANT_CODE};
            hpa_pkg::OFS_BUYER_IDENTIFIER:
                own_rdata = BUYER_CODE;
            hpa_pkg::OFS_PROGRAMMED_SETUP_REVISION:
                own_rdata = PROGRAMMED_SETUP;
            default:
                own_rdata = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // burst tracking
    // ----------------------------------------------------------------
    assign ptr_next = ptr_reg + 8'h01;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            hpa_pkg::HPA_ST_IDLE:
                if (xfer_valid && hit && !xfer_end)
                    state_next = hpa_pkg::HPA_ST_BURST;
            hpa_pkg::HPA_ST_BURST:
                if (xfer_end)
                    state_next = hpa_pkg::HPA_ST_IDLE;
            default:
                state_next = hpa_pkg::HPA_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state_reg <= hpa_pkg::HPA_ST_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ptr_reg <= hpa_pkg::RST_POINTER;
        else if (xfer_valid && hit)
            ptr_reg <= cur_byte;
    end

    // ----------------------------------------------------------------
    // second bus address configuration
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            second_msbs_reg <= SECOND_ADDR_LOADED[hpa_pkg::ADDR_MSBS_MSB:hpa_pkg::ADDR_MSBS_LSB];
            pin_choice_reg  <= SECOND_ADDR_LOADED[hpa_pkg::PIN_CHOICE_MSB:hpa_pkg::PIN_CHOICE_LSB];
        end
        else if (do_write && sel_addr_cfg)
        begin
            // reserved read-only bits 3:2 are dropped
            second_msbs_reg <= xfer_wdata[hpa_pkg::ADDR_MSBS_MSB:hpa_pkg::ADDR_MSBS_LSB];
            pin_choice_reg  <= xfer_wdata[hpa_pkg::PIN_CHOICE_MSB:hpa_pkg::PIN_CHOICE_LSB];
        end
    end

    // ----------------------------------------------------------------
    // page control
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            auto_return_reg <= hpa_pkg::RST_PAGE_CONTROL[hpa_pkg::AUTO_RETURN_BIT];
            write_style_reg <= hpa_pkg::RST_PAGE_CONTROL[hpa_pkg::WRITE_STYLE_BIT];
            page_rsvd_reg   <= hpa_pkg::RST_PAGE_CONTROL[hpa_pkg::PAGE_RSVD_MSB:hpa_pkg::PAGE_RSVD_LSB];
        end
        else if (do_write && sel_page_ctl)
        begin
            auto_return_reg <= xfer_wdata[hpa_pkg::AUTO_RETURN_BIT];
            write_style_reg <= xfer_wdata[hpa_pkg::WRITE_STYLE_BIT];
            page_rsvd_reg   <= xfer_wdata[hpa_pkg::PAGE_RSVD_MSB:hpa_pkg::PAGE_RSVD_LSB];
        end
    end

    // end-of-access clear beats a page write
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            page_sel_reg <= hpa_pkg::RST_PAGE_CONTROL[hpa_pkg::PAGE_SEL_MSB:hpa_pkg::PAGE_SEL_LSB];
        else if (xfer_end && (state_reg == hpa_pkg::HPA_ST_BURST || (xfer_valid && hit))
                 && ((do_write && sel_page_ctl) ? xfer_wdata[hpa_pkg::AUTO_RETURN_BIT]
                                                : auto_return_reg))
            page_sel_reg <= 3'h0;
        else if (do_write && sel_page_ctl)
            page_sel_reg <= xfer_wdata[hpa_pkg::PAGE_SEL_MSB:hpa_pkg::PAGE_SEL_LSB];
    end

    // ----------------------------------------------------------------
    // answer to the front end
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_reg    <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg  <= 8'h00;
        end
        else
        begin
            // read-only writes acked, dropped
            ack_reg    <= xfer_valid && hit;
            rvalid_reg <= xfer_valid && hit && !xfer_write;

            if (xfer_valid && hit && !xfer_write)
                rdata_reg <= (do_read && sel_own) ? own_rdata : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // forwarding to other banks
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ext_we_reg    <= 1'b0;
            ext_re_reg    <= 1'b0;
            ext_addr_reg  <= 10'h000;
            ext_wdata_reg <= 8'h00;
        end
        else
        begin
            ext_we_reg <= do_write && !sel_own;
            ext_re_reg <= do_read && !sel_own;

            if (do_access && !sel_own)
            begin
                ext_addr_reg  <= full_addr;
                ext_wdata_reg <= xfer_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign xfer_ack     = ack_reg;
    assign xfer_rvalid  = rvalid_reg;
    assign xfer_rdata   = rdata_reg;
    assign ext_we       = ext_we_reg;
    assign ext_re       = ext_re_reg;
    assign ext_addr     = ext_addr_reg;
    assign ext_wdata    = ext_wdata_reg;

    assign page_sel     = page_sel_reg;
    assign repeat_write = write_style_reg;

endmodule

// File: hpa_regbank_asserts.sv
// Purpose: port checks of the bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound into every hpa_regbank
`timescale 1ns/1ps
module hpa_regbank_asserts
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // byte access
    input wire logic       xfer_valid,
    input wire logic       xfer_spi,
    input wire logic       xfer_first,
    input wire logic       xfer_write,
    input wire logic [7:0] xfer_dev_byte,
    input wire logic [7:0] xfer_reg,
    input wire logic [7:0] xfer_wdata,
    input wire logic       xfer_end,
    // answers and state
    input wire logic       xfer_ack,
    input wire logic       xfer_rvalid,
    input wire logic       ext_we,
    input wire logic       ext_re,
    input wire logic [9:0] ext_addr,
    input wire logic [7:0] ext_wdata,
    input wire logic [2:0] page_sel,
    input wire logic       repeat_write
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_spi_always_acked: assert property (
        xfer_valid && xfer_spi |=> xfer_ack && xfer_rvalid == $past(!xfer_write))
        else $error("spi answer");
    a_refuse_bad_addr: assert property (
        xfer_valid && !xfer_spi && (xfer_dev_byte[3] || xfer_dev_byte[0] == xfer_write
        || xfer_dev_byte[2:1] == 2'b11) |=> !xfer_ack)
        else $error("bad addr acked");
    a_rvalid_after_read: assert property (
        xfer_rvalid |-> $past(xfer_valid && !xfer_write))
        else $error("stray rvalid");
    a_page_change_cause: assert property (
        $changed(page_sel) |-> $past(xfer_valid || xfer_end))
        else $error("stray page change");
    a_spi_low_window: assert property (
        xfer_valid && xfer_spi && xfer_first && xfer_write && page_sel[2:1] == 2'b00
        |=> ext_we && ext_addr == {2'b00, $past(page_sel[0]), $past(xfer_reg[6:0])})
        else $error("spi window addr");
    a_pair1_window: assert property (
        ext_we && $past(xfer_valid && !xfer_spi && xfer_first && xfer_dev_byte[2:1] == 2'b01)
        |-> ext_addr == {3'b010, $past(xfer_reg[6:0])})
        else $error("pair one addr");
    a_page0_window: assert property (
        ext_we && $past(xfer_valid && !xfer_spi && xfer_first && xfer_dev_byte[2:1] == 2'b00
        && page_sel[2:1] == 2'b00) |-> ext_addr == {2'b00, $past(xfer_reg)})
        else $error("page zero addr");
    a_repeat_same_reg: assert property (
        ext_we && $past(xfer_valid && !xfer_spi && !xfer_first && repeat_write)
        |-> ext_addr[6:0] == $past(xfer_reg[6:0]))
        else $error("repeat moved reg");
    a_bank_not_forward: assert property (
        ext_we || ext_re |-> ext_addr != 10'h148 && (ext_addr < 10'h200 || ext_addr > 10'h204))
        else $error("bank reg forwarded");
    a_fwd_wdata_kept: assert property (
        ext_we |-> ext_wdata == $past(xfer_wdata))
        else $error("fwd data");
endmodule

bind hpa_regbank hpa_regbank_asserts chk_u (.*);

// File: hpa_regbank_tb_top.sv
// Purpose: bench for the paging and address bank
// Assumes: default msbs 4'hd
// Notes:   fixed seed
`timescale 1ns/1ps
module hpa_regbank_tb_top;
    localparam logic [7:0] IDS [5] = '{8'h04, 8'h77, 8'h39, 8'ha6, 8'h12}; // IDS[0] matches the page control write 8'h04; others arbitrary
    localparam logic [8:0] BAD [5] = '{9'h0d0, 9'h1d1, 9'h1d6, 9'h1d8, 9'h160};
    logic       clk   = 1'b0;
    logic       rst_b = 1'b0;
    logic       input_pin_zero = 1'b0;
    logic       input_pin_one  = 1'b0;
    logic       input_pin_four = 1'b0;
    logic       xfer_valid, xfer_spi, xfer_first, xfer_write, xfer_end;
    logic       xfer_ack, xfer_rvalid, ext_we, ext_re, repeat_write;
    logic [7:0] xfer_dev_byte, xfer_reg, xfer_wdata, xfer_rdata, ext_wdata, r, wd, cfg, cfg_prev;
    logic [9:0] ext_addr;
    logic [2:0] page_sel, pg;
    logic [2:0] pins = 3'h0;
    logic [3:0] b;
    int         fail_count = 0;
    int         checked    = 0;

    always #2 clk = ~clk;

    hpa_host_model host_u (.*);
    hpa_regbank #(.PART_CODE(IDS[1]), .MASK_REVISION(IDS[2][7:4]), .VARIANT_CODE(IDS[2][3:0]),
        .BUYER_CODE(IDS[3]), .PROGRAMMED_SETUP(IDS[4])) dut_u (.*);

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr2(input logic [7:0] dev, rg, d);
        host_u.xfer(1'b1, 1'b0, 1'b1, 1'b1, dev, rg, d, 1'b1);
    endtask

    task automatic rd2(input logic [7:0] dev, rg);
        host_u.xfer(1'b1, 1'b0, 1'b1, 1'b0, dev, rg, 8'h00, 1'b1);
    endtask

    // expected two-wire address msbs
    function automatic logic [3:0] exp_base(input logic [7:0] c, input logic [2:0] p);
        logic on;
        on = (c[1:0] == 2'b01 && p[0]) || (c[1:0] == 2'b10 && p[1]) || (c[1:0] == 2'b11 && p[2]);
        return (on && c[7:4] != 4'h0) ? c[7:4] : 4'hd;
    endfunction

    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        end_of_test();
    end

    initial
    begin
        void'($urandom(32'h4a46115f));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk(16'({repeat_write, page_sel}), 16'h0000);
        wr2(8'hd4, 8'h00, 8'h04);
        for (int i = 0; i < 5; i++)
        begin
            if (i > 0)
                wr2(8'hd4, 8'(i), 8'($urandom));
            rd2(8'hd5, 8'(i));
            chk(16'({host_u.seen_ack, host_u.seen_rv, host_u.seen_rd}), 16'({2'b11, IDS[i]}));
        end
        host_u.xfer(1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1);
        chk(16'(host_u.seen_rd), 16'h0004);
        $display("test identification done");
        for (int i = 0; i < 5; i++)
        begin
            pg = 3'(i);
            r = 8'h50 + 8'($urandom % 32);
            wr2(8'hd4, 8'h00, {5'h00, pg});
            host_u.xfer(1'b1, 1'b1, 1'b1, 1'b1, 8'h00, r, 8'($urandom), 1'b1);
            chk(16'({host_u.seen_ack, host_u.seen_we}), 16'({1'b1, pg != 3'h3}));
            if (pg != 3'h3)
                chk(16'(host_u.seen_addr), 16'({pg, r[6:0]}));
        end
        $display("test spi windows done");
        for (int i = 0; i < 3; i++)
        begin
            pg = {2'(i), 1'($urandom)};
            r = 8'h50 + 8'($urandom % 32);
            wr2(8'hd4, 8'h00, {5'h00, pg});
            wr2(8'hd0, r, 8'($urandom));
            chk(16'({host_u.seen_we, host_u.seen_addr}), 16'({1'b1, 2'(i), 1'b0, r[6:0]}));
            wr2(8'hd0 | 8'(2 * i), r, 8'($urandom));
            chk(16'({host_u.seen_we, host_u.seen_addr}), 16'({1'b1, 2'(i), 1'b0, r[6:0]}));
        end
        foreach (BAD[k])
        begin
            host_u.xfer(1'b1, 1'b0, 1'b1, BAD[k][8], BAD[k][7:0], 8'h10, 8'h00, 1'b1);
            chk(16'(host_u.seen_ack), 16'h0000);
        end
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk(16'(page_sel), 16'h0000);
        $display("test two-wire windows done");
        host_u.xfer(1'b1, 1'b0, 1'b1, 1'b1, 8'hd4, 8'h00, 8'h82, 1'b0);
        chk(16'(page_sel), 16'h0002);
        host_u.xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1);
        chk(16'(page_sel), 16'h0000);
        rd2(8'hd5, 8'h00);
        chk(16'(host_u.seen_rd), 16'h0080);
        $display("test auto return done");
        for (int s = 0; s < 2; s++)
        begin
            wr2(8'hd4, 8'h00, {1'b0, 1'(s), 6'h00});
            chk(16'(repeat_write), 16'(s));
            r = 8'h50 + 8'($urandom % 16);
            wd = 8'h60 + 8'($urandom % 16);
            host_u.xfer(1'b1, 1'b0, 1'b1, 1'b1, 8'hd0, r, 8'h11, 1'b0);
            host_u.xfer(1'b1, 1'b0, 1'b0, 1'b1, 8'hd0, wd, 8'h22, 1'b1);
            chk(16'(host_u.seen_addr), (s != 0) ? 16'(wd) : 16'(r + 8'h01));
        end
        $display("test write style done");
        cfg_prev = 8'h00;
        for (int n = 0; n < 8; n++)
        begin
            cfg = {(n == 7) ? 4'h0 : 4'h6, 2'($urandom), 2'(n)};
            wr2({exp_base(cfg_prev, pins), 4'h2}, 8'h48, cfg);
            cfg_prev = cfg;
            pins = 3'($urandom);
            @(posedge clk);
            {input_pin_four, input_pin_one, input_pin_zero} <= pins;
            b = exp_base(cfg, pins);
            rd2({b, 4'h3}, 8'h48);
            chk(16'({host_u.seen_ack, host_u.seen_rd}), 16'({1'b1, cfg[7:4], 2'b00, cfg[1:0]}));
            wr2({(b == 4'hd) ? 4'h6 : 4'hd, 4'h0}, 8'h10, 8'h00);
            chk(16'(host_u.seen_ack), 16'h0000);
        end
        $display("test alternative address done");
        end_of_test();
    end
endmodule
